// [verilog/asbt_cfg.svh]
`ifndef ASBT_CFG_SVH
`define ASBT_CFG_SVH
// Summary of operation
// (RULE1) The bit-rate divisor k is an eight-bit value that is valid from 8 to 255.
// (RULE2) A four-bit selector picks the base clock that feeds the divisor counters.
// (RULE3) Software should use selector 1H with k 130 for 19200 bps and 2H with 130 for 9600 bps.
// (RULE4) Each bit after a start bit is sampled from the divisor counter, and the stop bit decides.
// (RULE5) A frame is eleven bits: start, eight data, parity and stop.
// (RULE6) The receive sampling point keeps a margin of two base clocks.
// (RULE7) Incoming rates up to 22k/(21k+2) of the programmed rate are accepted.
// (RULE8) Incoming rates down to 20k/(21k-2) of the programmed rate are accepted.
// (RULE9) The remote rate error must stay inside the band that the divisor allows.
// (RULE10) Software chooses base clock and divisor so the reception error stays in tolerance.
// (RULE11) Back-to-back frames get two extra base clocks between stop and next start.
// (RULE12) The receiver restarts its bit timing at every detected start bit.
// (RULE13) Bit rate is the base clock frequency divided by twice the divisor.
// (RULE14) While the unit power enable is low the base clock stays low.
// (RULE15) The receive counter starts on a start bit and halts after one frame.
// (RULE16) Transmit and receive have separate divisor counters on the same base clock and k.
`define ASBT_K_MIN      8'h08
`define ASBT_SEL_MAX    4'ha
`define ASBT_PRE_W      10
`define ASBT_FRAME_LAST 4'ha
`define ASBT_PARITY_IDX 4'h9
`define ASBT_GAP_TICKS  2'h2
`define ASBT_FIFO_DEPTH 8
`endif

// [verilog/asbt_pkg.sv]
package asbt_pkg;
    typedef enum logic [1:0] {ASBT_TX_IDLE, ASBT_TX_GAP, ASBT_TX_SHIFT} asbt_tx_st_t;
    typedef enum logic {ASBT_RX_IDLE, ASBT_RX_BUSY} asbt_rx_st_t;
    typedef struct packed {
        logic [7:0] data;
        logic       parity_err;
        logic       frame_err;
    } asbt_rx_word_t;
endpackage

// [verilog/asbt_top.sv]
`timescale 1ns/1ps
`include "asbt_cfg.svh"

module asbt_fifo
    import asbt_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign o_in_ready  = (cnt_q != DEPTH[AW:0]);
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data  = mem_q[rd_q];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule // asbt_fifo

module asbt_top
    import asbt_pkg::*;
#(
    parameter int FIFO_DEPTH = `ASBT_FIFO_DEPTH
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_unit_power_enable,
    input  wire logic       i_tx_enable,
    input  wire logic       i_rx_enable,
    input  wire logic [3:0] i_base_clock_select,
    input  wire logic [7:0] i_rate_divisor_value,
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_data,
    output logic            o_tx_ready,
    output logic            o_txd,
    input  wire logic       i_rxd,
    output logic            o_rx_valid,
    output asbt_rx_word_t   o_rx_word
);
    // Base clock divides fx by 2^select; selects beyond the table give no tick
    function automatic logic base_tick_of(input logic [`ASBT_PRE_W-1:0] pre,
                                          input logic [3:0] sel);
        logic [`ASBT_PRE_W:0] m;
        m = ({{`ASBT_PRE_W{1'b0}}, 1'b1} << sel) - {{`ASBT_PRE_W{1'b0}}, 1'b1};
        return (sel <= `ASBT_SEL_MAX) && ((pre & m[`ASBT_PRE_W-1:0]) == m[`ASBT_PRE_W-1:0]);
    endfunction

    // Values below the legal floor run as the floor
    function automatic logic [7:0] k_of(input logic [7:0] k);
        return (k < `ASBT_K_MIN) ? `ASBT_K_MIN : k;
    endfunction

    logic [`ASBT_PRE_W-1:0] pre_q;
    logic                   base_tick;
    logic [7:0]             k_eff;
    logic                   tx_on;
    logic                   rx_on;

    assign k_eff     = k_of(i_rate_divisor_value); // RULE1
    assign tx_on     = i_unit_power_enable && i_tx_enable;
    assign rx_on     = i_unit_power_enable && i_rx_enable;
    assign base_tick = i_unit_power_enable && base_tick_of(pre_q, i_base_clock_select); // RULE2 RULE14

    always_ff @(posedge i_clk) begin
        if (i_rst || !i_unit_power_enable) begin
            pre_q <= '0; // RULE14
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // Transmit path
    logic        f_valid;
    logic [7:0]  f_data;
    logic        f_pop;
    asbt_tx_st_t tx_st_q;
    logic [7:0]  tx_half_q;
    logic        tx_ph_q;
    logic [3:0]  tx_idx_q;
    logic [1:0]  tx_gap_q;
    logic [10:0] tx_sh_q;
    logic        tx_half_end;
    logic        tx_adv;
    logic        tx_load;

    asbt_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_in_valid  (i_tx_valid),
        .i_in_data   (i_tx_data),
        .o_in_ready  (o_tx_ready),
        .o_out_valid (f_valid),
        .o_out_data  (f_data),
        .i_out_ready (f_pop)
    );

    assign tx_half_end = base_tick && (tx_half_q == k_eff - 8'h01);
    assign tx_adv      = (tx_st_q == ASBT_TX_SHIFT) && tx_half_end && tx_ph_q; // RULE13
    assign tx_load     = tx_on && f_valid && base_tick &&
                         ((tx_st_q == ASBT_TX_IDLE) ||
                          (tx_st_q == ASBT_TX_GAP && tx_gap_q == `ASBT_GAP_TICKS - 2'h1));
    assign f_pop       = tx_load;
    assign o_txd       = tx_sh_q[0];

    always_ff @(posedge i_clk) begin
        if (i_rst || !tx_on) begin
            tx_st_q <= ASBT_TX_IDLE;
            tx_idx_q <= '0;
            tx_gap_q <= '0;
            tx_sh_q  <= '1;
        end else if (tx_load) begin
            tx_st_q  <= ASBT_TX_SHIFT;
            tx_idx_q <= '0;
            tx_sh_q  <= {1'b1, ^f_data, f_data, 1'b0}; // RULE5
        end else if (tx_st_q == ASBT_TX_GAP) begin
            if (base_tick) begin
                tx_gap_q <= tx_gap_q + 2'h1; // RULE11
            end
        end else if (tx_adv) begin
            tx_sh_q <= {1'b1, tx_sh_q[10:1]};
            if (tx_idx_q == `ASBT_FRAME_LAST) begin
                tx_st_q  <= f_valid ? ASBT_TX_GAP : ASBT_TX_IDLE; // RULE11
                tx_gap_q <= '0;
                tx_idx_q <= '0;
            end else begin
                tx_idx_q <= tx_idx_q + 4'h1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || !tx_on || tx_load || tx_st_q != ASBT_TX_SHIFT) begin
            tx_half_q <= '0;
            tx_ph_q   <= 1'b0;
        end else if (tx_half_end) begin
            tx_half_q <= '0; // RULE16
            tx_ph_q   <= ~tx_ph_q;
        end else if (base_tick) begin
            tx_half_q <= tx_half_q + 8'h01;
        end
    end

    // Receive path
    asbt_rx_st_t rx_st_q;
    logic        rxd_prev_q;
    logic [7:0]  rx_half_q;
    logic        rx_ph_q;
    logic [3:0]  rx_idx_q;
    logic [7:0]  rx_sh_q;
    logic        rx_par_q;
    logic        rx_start;
    logic        rx_sample;

    assign rx_start  = rx_on && (rx_st_q == ASBT_RX_IDLE) && rxd_prev_q && !i_rxd;
    // Sampling at mid-bit leaves about half a bit, less two base clocks, of slack
    assign rx_sample = (rx_st_q == ASBT_RX_BUSY) && base_tick &&
                       (rx_half_q == k_eff - 8'h01) && !rx_ph_q; // RULE4 RULE6 RULE7 RULE8

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rxd_prev_q <= 1'b1;
        end else begin
            rxd_prev_q <= i_rxd;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || !rx_on || rx_start || rx_st_q == ASBT_RX_IDLE) begin
            rx_half_q <= '0; // RULE12 RULE15
            rx_ph_q   <= 1'b0;
        end else if (base_tick && rx_half_q == k_eff - 8'h01) begin
            rx_half_q <= '0; // RULE16
            rx_ph_q   <= ~rx_ph_q;
        end else if (base_tick) begin
            rx_half_q <= rx_half_q + 8'h01;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || !rx_on) begin
            rx_st_q  <= ASBT_RX_IDLE;
            rx_idx_q <= '0;
            rx_sh_q  <= '0;
            rx_par_q <= 1'b0;
        end else if (rx_start) begin
            rx_st_q  <= ASBT_RX_BUSY; // RULE12
            rx_idx_q <= '0;
        end else if (rx_sample) begin
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q == 4'h0 && i_rxd) begin
                rx_st_q <= ASBT_RX_IDLE; // False start
            end else if (rx_idx_q == `ASBT_PARITY_IDX) begin
                rx_par_q <= i_rxd;
            end else if (rx_idx_q == `ASBT_FRAME_LAST) begin
                rx_st_q <= ASBT_RX_IDLE; // RULE15
            end else if (rx_idx_q != 4'h0) begin
                rx_sh_q <= {i_rxd, rx_sh_q[7:1]};
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rx_valid <= 1'b0;
            o_rx_word  <= '0;
        end else begin
            o_rx_valid <= rx_on && rx_sample && rx_idx_q == `ASBT_FRAME_LAST;
            if (rx_on && rx_sample && rx_idx_q == `ASBT_FRAME_LAST) begin
                o_rx_word.data       <= rx_sh_q;
                o_rx_word.parity_err <= (^rx_sh_q) != rx_par_q;
                o_rx_word.frame_err  <= !i_rxd; // RULE4
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    AST_K_FLOOR: assert property (k_eff >= `ASBT_K_MIN) // RULE1
        else $error("Divisor below floor");
    AST_SEL0_EVERY: assert property (i_unit_power_enable && i_base_clock_select == 4'h0
        |-> base_tick) // RULE2
        else $error("Select 0 must tick every cycle");
    AST_UNPOWERED_LOW: assert property (!i_unit_power_enable |-> !base_tick
        ##1 (pre_q == '0 || i_unit_power_enable)) // RULE14
        else $error("Base clock ran while unpowered");
    AST_TX_START_LOW: assert property (tx_st_q == ASBT_TX_SHIFT && tx_idx_q == 4'h0
        |-> !o_txd) // RULE5
        else $error("Start bit not low");
    AST_TX_GAP_ENTRY: assert property (tx_on && tx_adv && tx_idx_q == `ASBT_FRAME_LAST
        && f_valid |=> tx_st_q == ASBT_TX_GAP && o_txd) // RULE11
        else $error("No gap between back-to-back frames");
    AST_RX_RESTART: assert property (rx_start |=> rx_st_q == ASBT_RX_BUSY
        && rx_half_q == '0 && rx_idx_q == '0) // RULE12
        else $error("Start did not restart receive timing");
    AST_RX_HALTED: assert property (rx_st_q == ASBT_RX_IDLE && !rx_start
        |=> rx_half_q == '0 && !rx_ph_q) // RULE15
        else $error("Receive counter ran outside a frame");
    AST_RX_DONE_AT_STOP: assert property (o_rx_valid |-> $past(rx_idx_q) == `ASBT_FRAME_LAST
        && rx_st_q == ASBT_RX_IDLE) // RULE4
        else $error("Frame completed off the stop sample");
    AST_COUNTERS_BOUND: assert property (tx_half_q < k_eff && rx_half_q < k_eff) // RULE16
        else $error("Divisor counter beyond k");

    // The line may only move on a bit boundary or a fresh load
    AST_TX_BIT_HOLD: assert property (tx_on && !tx_adv && !tx_load // RULE13
        |=> $stable(o_txd))
        else $error("Serial output moved inside a bit");
    AST_TX_IDLE_HIGH: assert property (tx_st_q == ASBT_TX_IDLE |-> o_txd) // RULE11
        else $error("Serial output low while idle");
    AST_TX_OFF_IDLE: assert property (!tx_on // RULE14
        |=> tx_st_q == ASBT_TX_IDLE && o_txd)
        else $error("Transmitter ran while disabled");
    AST_RX_VALID_PULSE: assert property (o_rx_valid |=> !o_rx_valid) // RULE15
        else $error("Receive valid held longer than one cycle");
    AST_RX_WORD_STANDS: assert property (!o_rx_valid |-> $stable(o_rx_word)) // RULE15
        else $error("Receive word changed without a frame");
    AST_RX_FALSE_START: assert property (rx_sample && rx_idx_q == 4'h0 && i_rxd // RULE4
        |=> rx_st_q == ASBT_RX_IDLE && !o_rx_valid)
        else $error("High start sample did not drop the frame");

    COV_RX_FRAME: cover property (o_rx_valid && !o_rx_word.frame_err);
    COV_TX_GAP: cover property (tx_st_q == ASBT_TX_GAP ##[1:300] tx_st_q == ASBT_TX_SHIFT);
    COV_FIFO_FULL: cover property (!o_tx_ready);
    COV_RX_FALSE_START: cover property (rx_sample && rx_idx_q == 4'h0 && i_rxd);
endmodule // asbt_top

// [tb/asbt_remote_model.sv]
`timescale 1ns/1ps

module asbt_remote_model (
    input  wire logic i_clk,
    input  wire logic i_line_in,
    output logic      o_line_out
);
    int          cyc;
    int          rx_period;
    logic [10:0] rx_q[$];
    int          rx_t_q[$];

    initial begin
        o_line_out = 1'b1;
        rx_period  = 16;
    end

    always @(posedge i_clk) cyc <= cyc + 1;

    // Bit time per call sets the remote rate error against the receiver
    task automatic send(input logic [7:0] b, input int per, input logic bad_par,
                        input logic stop);
        logic [10:0] f;
        f = {stop, (^b) ^ bad_par, b, 1'b0};
        @(negedge i_clk);
        for (int i = 0; i < 11; i++) begin
            o_line_out = f[i];
            repeat (per) @(negedge i_clk);
        end
        if (!stop) begin
            o_line_out = 1'b1;
            repeat (per) @(negedge i_clk);
        end
    endtask

    // Short low pulse that must read as a false start
    task automatic glitch(input int n);
        @(negedge i_clk);
        o_line_out = 1'b0;
        repeat (n) @(negedge i_clk);
        o_line_out = 1'b1;
    endtask

    // Mid-bit sampling; no wait after the stop so a short gap is still seen
    always begin
        logic [10:0] f;
        int          t;
        @(negedge i_line_in);
        t = cyc;
        repeat (rx_period / 2) @(posedge i_clk);
        for (int i = 0; i < 11; i++) begin
            f[i] = i_line_in;
            if (i < 10) repeat (rx_period) @(posedge i_clk);
        end
        rx_q.push_back(f);
        rx_t_q.push_back(t);
    end
endmodule // asbt_remote_model

// [tb/tb.sv]
`timescale 1ns/1ps

module tb;
    import asbt_pkg::*;
    logic          clk;
    logic          rst;
    logic          pwr;
    logic          tx_en;
    logic          rx_en;
    logic [3:0]    sel;
    logic [7:0]    kdiv;
    logic          tx_valid;
    logic [7:0]    tx_data;
    logic          tx_ready;
    logic          txd;
    logic          rxd;
    logic          rx_valid;
    asbt_rx_word_t rx_word;
    asbt_rx_word_t got_q[$];
    int            failures;
    int            n_checks;

    asbt_top DUT (.i_clk(clk), .i_rst(rst), .i_unit_power_enable(pwr), .i_tx_enable(tx_en),
        .i_rx_enable(rx_en), .i_base_clock_select(sel), .i_rate_divisor_value(kdiv),
        .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready), .o_txd(txd),
        .i_rxd(rxd), .o_rx_valid(rx_valid), .o_rx_word(rx_word));

    asbt_remote_model u_model (.i_clk(clk), .i_line_in(txd), .o_line_out(rxd));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) if (rx_valid === 1'b1) got_q.push_back(rx_word);

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_word(input asbt_rx_word_t got, input asbt_rx_word_t exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        if (failures == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Fill with the sender held off, then drain back to back
    task automatic t_tx_fill;
        logic [7:0] pat[8] = '{8'h00, 8'hff, 8'ha5, 8'h5a, 8'h01, 8'h80, 8'h3c, 8'hc3};
        int         n;
        n = 0;
        while (tx_ready === 1'b1 && n < 12) begin
            tx_valid = 1'b1;
            tx_data  = pat[n % 8];
            @(negedge clk);
            n++;
        end
        tx_valid = 1'b0;
        check_val(n, 8);
        check_val(txd, 1'b1);
        tx_en = 1'b1;
        for (int i = 0; i < 4000 && u_model.rx_q.size() < 8; i++) @(negedge clk);
        check_val(u_model.rx_q.size(), 8);
        for (int i = 0; i < 8 && i < u_model.rx_q.size(); i++) begin
            check_val(u_model.rx_q[i], {1'b1, ^pat[i], pat[i], 1'b0});
            if (i > 0) check_val(u_model.rx_t_q[i] - u_model.rx_t_q[i-1], 178);
        end
    endtask

    // Second frame follows the first with no idle gap, except one bit of idle after a low stop
    task automatic t_rx(input int per, input logic [7:0] b, input logic bp, input logic st);
        asbt_rx_word_t exp;
        exp = '{data: b, parity_err: bp, frame_err: ~st};
        got_q.delete();
        u_model.send(b, per, bp, st);
        u_model.send(~b, per, 1'b0, 1'b1);
        for (int i = 0; i < 4 * per && got_q.size() < 2; i++) @(negedge clk);
        check_val(got_q.size(), 2);
        if (got_q.size() == 2) begin
            check_word(got_q[0], exp);
            check_word(got_q[1], '{data: ~b, parity_err: 1'b0, frame_err: 1'b0});
        end
    endtask

    // Low pulse shorter than half a bit must not yield a frame
    task automatic t_glitch;
        got_q.delete();
        u_model.glitch(4);
        repeat (400) @(negedge clk);
        check_val(got_q.size(), 0);
    endtask

    task automatic t_power;
        int n0;
        n0 = u_model.rx_q.size();
        got_q.delete();
        pwr      = 1'b0;
        tx_valid = 1'b1;
        tx_data  = 8'h77;
        @(negedge clk);
        tx_valid = 1'b0;
        u_model.send(8'h33, 32, 1'b0, 1'b1);
        repeat (64) @(negedge clk);
        check_val(got_q.size(), 0);
        check_val(u_model.rx_q.size(), n0);
        check_val(txd, 1'b1);
    endtask

    initial begin
        rst      = 1'b1;
        pwr      = 1'b1;
        tx_en    = 1'b0;
        rx_en    = 1'b1;
        sel      = 4'h0;
        kdiv     = 8'h08;
        tx_valid = 1'b0;
        tx_data  = 8'h00;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_tx_fill;
        t_rx(16, 8'h96, 1'b0, 1'b1);
        kdiv = 8'h04;
        t_rx(16, 8'h69, 1'b0, 1'b1);
        kdiv = 8'hff;
        t_rx(510, 8'he1, 1'b0, 1'b1);
        kdiv = 8'h08;
        sel  = 4'h1;
        t_rx(31, 8'h4b, 1'b1, 1'b1);
        t_rx(33, 8'hd2, 1'b0, 1'b0);
        t_glitch;
        kdiv = 8'h82;
        t_rx(520, 8'h3c, 1'b0, 1'b1);
        sel  = 4'h2;
        t_rx(1040, 8'hc3, 1'b0, 1'b1);
        t_power;
        wrap_up;
    end

    // Longest exchange is the slowest setting, near 23000 cycles; whole run near 50000
    initial begin
        repeat (80000) @(posedge clk);
        failures++;
        wrap_up;
    end
endmodule // tb
